// ===== hdl/tcc_defs.svh
// constants for the twelve-bit timer with capture and compare
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
// register offsets on the plain register port
`define TCC_ADDR_CTRL   3'h0
`define TCC_ADDR_CFG    3'h1
`define TCC_ADDR_CNTLO  3'h2
`define TCC_ADDR_CAPLO  3'h3
`define TCC_ADDR_HIGH   3'h4
// control register fields
`define TCC_CTRL_EXF    6
`define TCC_CTRL_OVF    7
// reset values
`define TCC_CTRL_RST    8'h00
`define TCC_CFG_RST     8'h00
`define TCC_BYTE_ZERO   8'h00
`define TCC_NIB_ZERO    4'h0
// counter limits
`define TCC_CNT_ZERO    12'h000
`define TCC_CNT_MAX     12'hFFF
`define TCC_CNT_ONE     12'h001
// prescaler terminal counts for divide by 4, 16, 32, 128
`define TCC_DIV4_TOP    7'h03
`define TCC_DIV16_TOP   7'h0F
`define TCC_DIV32_TOP   7'h1F
`define TCC_DIV128_TOP  7'h7F
`define TCC_PRES_ZERO   7'h00
`define TCC_PRES_ONE    7'h01
`endif

// ===== hdl/tcc_pkg.sv
// types shared by the twelve-bit timer with capture and compare
package tcc_pkg;
  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_CAPTURE,
    MODE_RELOAD,
    MODE_COMPARE
  } tcc_mode_t;

  // control register, bit 7 down to bit 0
  typedef struct packed {
    logic      ovfFlag;
    logic      extEventFlag;
    logic      pinToggleEnable;
    logic      counterSelect;
    logic      resetOnEvent;
    logic      timerRun;
    tcc_mode_t mode;
  } tcc_ctrl_t;

  // configuration register, bit 7 down to bit 0
  typedef struct packed {
    logic [3:0] spare;
    logic       irqEnable;
    logic       captureSourceSelect;
    logic [1:0] divSel;
  } tcc_cfg_t;
endpackage : tcc_pkg

// ===== hdl/tcc_timer.sv
// twelve-bit timer with counter, capture, auto-reload and compare modes
//
// How it works
// - a single twelve-bit up counter running in one of four modes
// - two-bit mode field: 00 timer, 01 capture, 10 reload, 11 compare
// - timer mode counts 000h to FFFh and wraps, reset-on-event ignored
// - software writes to the count take effect only while run is clear
// - tick is the clock divided by 4, 16, 32 or 128
// - count is a low byte plus bits 3..0 of the shared high register
// - counter select picks prescaled ticks or falling pin edges
// - pin sampled once per machine cycle; high then low counts one
// - with toggle enable the pin toggles on overflow or compare match
// - capture copies count: low byte and top nibble to bits 7..4
// - capture sets the event flag; it requests irq when enabled and stays until cleared
// - in capture mode reset-on-event clears the count after capture
// - capture source select picks pin or ADC comparator result
// - compare match sets the event flag and requests irq when enabled
// - compare: without reset-on-event count to overflow, with it reset
// - reload mode loads count from reload value on overflow, sets flag
// - reload mode runs from reload value up to FFFh
//
// Local design decisions: the address-and-strobe port and the register addresses.
`include "tcc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tcc_timer
  import tcc_pkg::*;
#(
  parameter int MC_CLKS = 4
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  input  wire logic       timer3PinIn,
  output logic            timer3PinOut,
  output logic            timer3PinOe,
  input  wire logic       adcCompareResult,
  output logic            timer3Irq
);

  localparam int MCW = (MC_CLKS > 1) ? $clog2(MC_CLKS) : 1;
  localparam logic [MCW-1:0] MC_LAST = MCW'(MC_CLKS - 1);
  localparam logic [MCW-1:0] MC_ZERO = '0;
  localparam logic [MCW-1:0] MC_ONE  = MCW'(1);

  // the machine cycle needs at least two clocks to have a C4 slot
  if (MC_CLKS < 2) begin : g_bad_mc
    $error("MC_CLKS must be at least 2");
  end

  // prescaler terminal count for the selected ratio
  function automatic logic [6:0] divTop(input logic [1:0] sel);
    case (sel)
      2'h0:    divTop = `TCC_DIV4_TOP;
      2'h1:    divTop = `TCC_DIV16_TOP;
      2'h2:    divTop = `TCC_DIV32_TOP;
      default: divTop = `TCC_DIV128_TOP;
    endcase
  endfunction : divTop

  logic            rstMeta_q;
  logic            rstSync_q;
  tcc_ctrl_t       ctrl_q;
  tcc_ctrl_t       ctrl_d;
  tcc_cfg_t        cfg_q;
  logic [11:0]     cnt_q;
  logic [11:0]     cnt_d;
  logic [7:0]      capLow_q;
  logic [7:0]      capLow_d;
  logic [3:0]      capHigh_q;
  logic [3:0]      capHigh_d;
  logic [6:0]      presCnt_q;
  logic [MCW-1:0]  mcCnt_q;
  logic            pinSmp_q;
  logic            fallEv_q;
  logic            trigPrev_q;
  logic [7:0]      regRdata_q;
  logic            pinOut_q;
  logic            pinOe_q;
  logic            irq_q;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // address decode and strobes
  wire wrCtrl  = regWrite && (regAddr == `TCC_ADDR_CTRL);
  wire wrCfg   = regWrite && (regAddr == `TCC_ADDR_CFG);
  wire wrCntLo = regWrite && (regAddr == `TCC_ADDR_CNTLO);
  wire wrCapLo = regWrite && (regAddr == `TCC_ADDR_CAPLO);
  wire wrHigh  = regWrite && (regAddr == `TCC_ADDR_HIGH);
  wire cntWrOk = !ctrl_q.timerRun;

  // prescaler and machine cycle phase
  wire presTick = (presCnt_q >= divTop(cfg_q.divSel));
  wire atC4     = (mcCnt_q == MC_LAST);

  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      presCnt_q <= `TCC_PRES_ZERO;
      mcCnt_q   <= MC_ZERO;
    end else begin
      presCnt_q <= presTick ? `TCC_PRES_ZERO : presCnt_q + `TCC_PRES_ONE;
      mcCnt_q   <= atC4 ? MC_ZERO : mcCnt_q + MC_ONE;
    end
  end

  // pin sampled at C4; a high sample followed by a low one is an edge
  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      pinSmp_q <= 1'b0;
      fallEv_q <= 1'b0;
    end else if (atC4) begin
      pinSmp_q <= timer3PinIn;
      fallEv_q <= pinSmp_q && !timer3PinIn;
    end else begin
      fallEv_q <= 1'b0;
    end
  end

  // capture trigger: either pin edge, or rising comparator result
  wire capSrc  = cfg_q.captureSourceSelect ? adcCompareResult
                                           : timer3PinIn;
  wire capEdge = cfg_q.captureSourceSelect ? (capSrc && !trigPrev_q)
                                           : (capSrc ^ trigPrev_q);

  // previous trigger level starts high, as the pin idles, so no false
  // capture edge follows reset; a rising ADC edge still needs a low first
  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      trigPrev_q <= 1'b1;
    end else begin
      trigPrev_q <= capSrc;
    end
  end

  // count events and mode conditions
  wire        incEv   = ctrl_q.timerRun &&
                        (ctrl_q.counterSelect ? fallEv_q : presTick);
  wire        atMax   = (cnt_q == `TCC_CNT_MAX);
  wire        ovfEv   = incEv && atMax;
  wire [11:0] refVal  = {capHigh_q, capLow_q};
  wire        isCap   = (ctrl_q.mode == MODE_CAPTURE);
  wire        isRld   = (ctrl_q.mode == MODE_RELOAD);
  wire        isCmp   = (ctrl_q.mode == MODE_COMPARE);
  wire        capEv   = isCap && capEdge;
  wire        matchEv = isCmp && incEv && (cnt_q == refVal);
  wire        cmpRst  = matchEv && ctrl_q.resetOnEvent;
  wire        capRst  = capEv && ctrl_q.resetOnEvent;
  wire        toggle  = ovfEv || matchEv;

  // next count; a reset after capture or match beats the increment
  always_comb begin
    cnt_d = cnt_q;
    if (capRst || cmpRst) begin
      cnt_d = `TCC_CNT_ZERO;
    end else if (ovfEv && isRld) begin
      cnt_d = refVal;
    end else if (incEv) begin
      cnt_d = cnt_q + `TCC_CNT_ONE;
    end else if (cntWrOk) begin
      if (wrCntLo) begin
        cnt_d = {cnt_q[11:8], regWdata};
      end else if (wrHigh) begin
        cnt_d = {regWdata[3:0], cnt_q[7:0]};
      end
    end
  end

  // capture, reload and compare value; a capture wins over a write
  always_comb begin
    capLow_d  = capLow_q;
    capHigh_d = capHigh_q;
    if (capEv) begin
      capLow_d  = cnt_q[7:0];
      capHigh_d = cnt_q[11:8];
    end else begin
      if (wrCapLo) begin
        capLow_d = regWdata;
      end
      if (wrHigh) begin
        capHigh_d = regWdata[7:4];
      end
    end
  end

  // control register; hardware setting a flag wins over a software clear
  always_comb begin
    ctrl_d = ctrl_q;
    if (wrCtrl) begin
      ctrl_d = tcc_ctrl_t'(regWdata);
      ctrl_d.extEventFlag = regWdata[`TCC_CTRL_EXF] & ctrl_q.extEventFlag;
      ctrl_d.ovfFlag      = regWdata[`TCC_CTRL_OVF] & ctrl_q.ovfFlag;
    end
    if (capEv || matchEv) begin
      ctrl_d.extEventFlag = 1'b1;
    end
    if (ovfEv) begin
      ctrl_d.ovfFlag = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      ctrl_q    <= tcc_ctrl_t'(`TCC_CTRL_RST);
      cfg_q     <= tcc_cfg_t'(`TCC_CFG_RST);
      cnt_q     <= `TCC_CNT_ZERO;
      capLow_q  <= `TCC_BYTE_ZERO;
      capHigh_q <= `TCC_NIB_ZERO;
    end else begin
      ctrl_q    <= ctrl_d;
      cnt_q     <= cnt_d;
      capLow_q  <= capLow_d;
      capHigh_q <= capHigh_d;
      if (wrCfg) begin
        cfg_q <= tcc_cfg_t'({4'h0, regWdata[3:0]});
      end
    end
  end

  // read mux; unmapped offsets read as zero
  logic [7:0] rdMux;
  always_comb begin
    case (regAddr)
      `TCC_ADDR_CTRL:  rdMux = ctrl_q;
      `TCC_ADDR_CFG:   rdMux = cfg_q;
      `TCC_ADDR_CNTLO: rdMux = cnt_q[7:0];
      `TCC_ADDR_CAPLO: rdMux = capLow_q;
      `TCC_ADDR_HIGH:  rdMux = {capHigh_q, cnt_q[11:8]};
      default:         rdMux = `TCC_BYTE_ZERO;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      regRdata_q <= `TCC_BYTE_ZERO;
    end else begin
      regRdata_q <= regRead ? rdMux : `TCC_BYTE_ZERO;
    end
  end

  // pin drive and interrupt request, both registered
  wire irqFlags = ctrl_q.extEventFlag || ctrl_q.ovfFlag;

  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      pinOut_q <= 1'b0;
      pinOe_q  <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      pinOe_q <= ctrl_q.pinToggleEnable;
      if (ctrl_q.pinToggleEnable && toggle) begin
        pinOut_q <= !pinOut_q;
      end
      irq_q <= irqFlags && cfg_q.irqEnable;
    end
  end

  assign regRdata     = regRdata_q;
  assign timer3PinOut = pinOut_q;
  assign timer3PinOe  = pinOe_q;
  assign timer3Irq    = irq_q;

endmodule : tcc_timer

`default_nettype wire

// ===== sim/tcc_pin_src.sv
// model of the external timer pin and the converter comparator line
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_src #(
  parameter int MC_CLKS = 4
) (
  input  wire logic ref_clk,
  output var logic  pinLevel,
  output var logic  adcLevel
);
  // pin idles high, comparator idles low
  initial begin
    pinLevel = 1'b1;
    adcLevel = 1'b0;
  end
  // each level stands two machine cycles so one sample cannot miss it
  task automatic pin_to(input logic v);
    @(posedge ref_clk);
    pinLevel <= v;
    repeat (2 * MC_CLKS) @(posedge ref_clk);
  endtask : pin_to
  // one comparator pulse, the rising edge is the trigger
  task automatic adc_pulse();
    @(posedge ref_clk);
    adcLevel <= 1'b1;
    repeat (2 * MC_CLKS) @(posedge ref_clk);
    adcLevel <= 1'b0;
    repeat (2 * MC_CLKS) @(posedge ref_clk);
  endtask : adc_pulse
endmodule : tcc_pin_src
`default_nettype wire

// ===== sim/tcc_timer_chk.sv
// port assertions for the twelve-bit timer
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_chk #(
  parameter int MC_CLKS = 4
) (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       timer3PinIn,
  input wire logic       timer3PinOut,
  input wire logic       timer3PinOe,
  input wire logic       adcCompareResult,
  input wire logic       timer3Irq
);
  logic [5:0] ctrl_q;
  logic       irqEn_q;
  wire        ctrlWr = regWrite && regAddr == 3'h0;
  // capture mode excluded: a pin edge may overwrite the shared byte
  wire        cntWr  = regWrite && !ctrl_q[2] && ctrl_q[1:0] != 2'h1 &&
                       (regAddr == 3'h2 || regAddr == 3'h4);
  // shadow of the software control bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= 6'h00;
      irqEn_q <= 1'b0;
    end else begin
      if (ctrlWr) ctrl_q <= regWdata[5:0];
      if (regWrite && regAddr == 3'h1) irqEn_q <= regWdata[3];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_gap_rd(a);
    !regWrite ##1 regRead && regAddr == a;
  endsequence
  a_rdata_idle: assert property (
    !$past(regRead) |-> regRdata == 8'h00) else $error("stray read data");
  a_unmapped_zero: assert property (
    regRead && regAddr > 3'h4 |=> regRdata == 8'h00) else $error("hole read");
  a_cfg_spare: assert property (
    regRead && regAddr == 3'h1 |=> regRdata[7:4] == 4'h0) else $error("spare");
  a_ctrl_readback: assert property (
    ctrlWr ##1 s_gap_rd(3'h0) |=> regRdata[5:0] == $past(regWdata[5:0], 3))
    else $error("control readback wrong");
  a_count_load: assert property (
    cntWr ##1 s_gap_rd($past(regAddr, 2)) |=> regRdata == $past(regWdata, 3))
    else $error("stopped count write lost");
  a_oe_follow: assert property (
    ctrlWr ##1 !ctrlWr |=> timer3PinOe == $past(regWdata[5], 2))
    else $error("pin enable wrong");
  a_pin_still: assert property (
    $changed(timer3PinOut) |-> timer3PinOe || $past(timer3PinOe))
    else $error("pin toggled while disabled");
  a_irq_gated: assert property (
    !irqEn_q && !$past(irqEn_q) |-> !timer3Irq) else $error("irq unmasked");
  a_irq_raised: assert property (
    regRead && regAddr == 3'h0 ##1 regRdata[7:6] != 2'h0 && $past(irqEn_q)
    |-> timer3Irq) else $error("irq missing");
endmodule : tcc_timer_chk
bind tcc_timer tcc_timer_chk #(.MC_CLKS(MC_CLKS)) i_tcc_timer_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .timer3PinIn(timer3PinIn), .timer3PinOut(timer3PinOut),
  .timer3PinOe(timer3PinOe), .adcCompareResult(adcCompareResult),
  .timer3Irq(timer3Irq));
`default_nettype wire

// ===== sim/twelve_bit_timer_capture_compare_test.sv
// self-checking bench for the twelve-bit timer
`timescale 1ns/1ps
`default_nettype none
module twelve_bit_timer_capture_compare_test;
  logic        ref_clk, rst_n, regWrite, regRead, pinWas;
  logic [2:0]  regAddr;
  logic [7:0]  regWdata, regRdata, pre;
  logic        pinLevel, adcLevel, pinOut, pinOe, irq;
  logic        rdSeen = 1'b0;
  logic [15:0] expQ[$];
  logic [15:0] e;
  logic [15:0] lfsr = 16'hA4CF;
  int          nErrors = 0;
  int          nTests = 0;
  int          divs[4] = '{4, 16, 32, 128};
  tcc_timer #(.MC_CLKS(4)) i_tcc_timer (.ref_clk(ref_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .timer3PinIn(pinLevel),
    .timer3PinOut(pinOut), .timer3PinOe(pinOe), .adcCompareResult(adcLevel),
    .timer3Irq(irq));
  tcc_pin_src i_tcc_pin_src (.ref_clk(ref_clk), .pinLevel(pinLevel),
    .adcLevel(adcLevel));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic chk(input string what, input logic [7:0] seen, exp, m);
    nTests++;
    if ((seen & m) !== (exp & m)) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp & m, seen & m);
    end
  endtask : chk
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : testDone
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : wr
  // the reply is compared one edge later by the watcher below
  task automatic rd(input logic [2:0] a, input logic [7:0] x, m);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    expQ.push_back({m, x});
    @(posedge ref_clk);
    regRead <= 1'b0;
  endtask : rd
  // run window of exactly div edges holds one prescaler tick
  task automatic tick_run(input logic [7:0] c, input int div);
    wr(3'h0, c | 8'hC4);
    repeat (div - 4) @(posedge ref_clk);
    wr(3'h2, 8'h55);
    wr(3'h0, c | 8'hC0);
  endtask : tick_run
  // clock and watchdog; a hang counts as a mismatch
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    nErrors++;
    $display("watchdog expired");
    testDone();
  end
  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rdSeen && expQ.size() > 0) begin
      e = expQ.pop_front();
      chk("read data", regRdata, e[7:0], e[15:8]);
    end else if (rdSeen) begin
      nErrors++;
      $display("CHECK FAILED read note expected queued seen none");
    end
    rdSeen <= regRead;
  end
  initial begin
    {regWrite, regRead, regAddr, regWdata, rst_n} = '0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00, 8'hFF);
    for (int m = 0; m < 4; m++) begin
      wr(3'h0, 8'(m));
      rd(3'h0, 8'(m), 8'h3F);
    end
    $display("reset and modes done");
    for (int d = 0; d < 4; d++) begin
      wr(3'h0, 8'h20);
      wr(3'h1, 8'h08 | 8'(d));
      wr(3'h2, 8'hFF);
      wr(3'h4, 8'h0F);
      pinWas = pinOut;
      tick_run(8'h20, divs[d]);
      rd(3'h2, 8'h00, 8'hFF);
      rd(3'h4, 8'h00, 8'h0F);
      rd(3'h0, 8'h80, 8'hC0);
      chk("irq", {7'h0, irq}, 8'h01, 8'h01);
      chk("pin", {7'h0, pinOut}, {7'h0, !pinWas}, 8'h01);
    end
    wr(3'h0, 8'h00);
    rd(3'h0, 8'h00, 8'hC0);
    chk("irq", {7'h0, irq}, 8'h00, 8'h01);
    $display("overflow done");
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h02);
    wr(3'h3, 8'hBC);
    wr(3'h4, 8'hAF);
    wr(3'h2, 8'hFF);
    tick_run(8'h02, 4);
    rd(3'h2, 8'hBC, 8'hFF);
    rd(3'h4, 8'hAA, 8'hFF);
    rd(3'h0, 8'h80, 8'hC0);
    for (int r = 0; r < 2; r++) begin
      wr(3'h0, 8'h03 | 8'(r << 3));
      wr(3'h3, 8'h05);
      wr(3'h4, 8'h00);
      wr(3'h2, 8'h05);
      tick_run(8'h03 | 8'(r << 3), 4);
      rd(3'h2, r ? 8'h00 : 8'h06, 8'hFF);
      rd(3'h0, 8'h40, 8'hC0);
    end
    $display("reload and compare done");
    for (int s = 0; s < 2; s++) begin
      lfsr = lfsr_next(lfsr);
      pre = lfsr[7:0];
      wr(3'h1, 8'(s << 2));
      wr(3'h0, 8'h01 | 8'(s << 3));
      wr(3'h4, 8'h03);
      wr(3'h2, pre);
      if (s == 0) begin
        i_tcc_pin_src.pin_to(1'b0);
        i_tcc_pin_src.pin_to(1'b1);
      end else begin
        i_tcc_pin_src.adc_pulse();
      end
      rd(3'h3, pre, 8'hFF);
      rd(3'h4, 8'h30, 8'hF0);
      rd(3'h2, s ? 8'h00 : pre, 8'hFF);
      rd(3'h0, 8'h40, 8'hC0);
    end
    $display("capture done");
    lfsr = lfsr_next(lfsr);
    pre = {1'b0, lfsr[6:0]};
    wr(3'h0, 8'h10);
    wr(3'h2, pre);
    rd(3'h2, pre, 8'hFF);
    wr(3'h4, 8'h00);
    wr(3'h0, 8'hD4);
    repeat (2) begin
      i_tcc_pin_src.pin_to(1'b0);
      i_tcc_pin_src.pin_to(1'b1);
    end
    wr(3'h0, 8'hD0);
    rd(3'h2, pre + 8'h02, 8'hFF);
    @(posedge ref_clk);
    $display("counter done");
    testDone();
  end
endmodule : twelve_bit_timer_capture_compare_test
`default_nettype wire
